// [core/gpd_port.sv]
// one port: direction, output value and synchronised pin levels
`timescale 1ns/1ps
module gpd_port #(
  parameter int W = 5
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] pin_in,
  gpd_port_if.port          bus
);

  typedef struct packed {
    logic [W-1:0] dir;
    logic [W-1:0] out;
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
  } gpd_port_st_t;

  gpd_port_st_t st_r;
  gpd_port_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    // first stage feeds only the second stage
    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;
    if (bus.wr_dir) begin
      st_nxt.dir = bus.dir_wd; // see RQ1 see RQ6
    end
    if (bus.wr_out) begin
      st_nxt.out = bus.out_wd; // see RQ2 see RQ7
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.dir   <= {W{gpd_pkg::DIR_RST}}; // see RQ11
      st_r.out   <= {W{gpd_pkg::OUT_RST}}; // see RQ11
      st_r.sync1 <= '0;
      st_r.sync2 <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.dir     = st_r.dir;
  assign bus.out     = st_r.out;
  assign bus.pin_lvl = st_r.sync2; // see RQ3 see RQ8
endmodule

// [core/gpd_top.sv]
// apb slave with the data/direction registers of gpio ports 0 and 1
// Contract
// RQ1 - port 0 word bits 28..24 set pins 4..0 as input (0) or output (1).
// RQ2 - port 0 bits 20..16 are driven onto pins 4..0 while they are outputs.
// RQ3 - port 0 bits 4..0 read the pin levels and ignore writes.
// RQ4 - software writes zero to every reserved bit of both words.
// RQ5 - software should write zero to the pin-level bits.
// RQ6 - port 1 word bits 25..24 set pins 1..0 as input (0) or output (1).
// RQ7 - port 1 bits 17..16 are driven onto pins 1..0 while they are outputs.
// RQ8 - port 1 bits 1..0 read the pin levels and ignore writes.
// RQ9 - port 1 word sits at its fixed address, upper bits zero at reset.
// RQ10 - port 0 word sits at its fixed address, holding all three groups.
// RQ11 - reset clears direction and output bits; a pin drives only as output.
`timescale 1ns/1ps
module gpd_top #(
  parameter int P0_W = gpd_pkg::P0_W,
  parameter int P1_W = gpd_pkg::P1_W
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  input  wire logic        first_port_line_zero_in,
  output wire logic        first_port_line_zero_out,
  output wire logic        first_port_line_zero_oe,
  input  wire logic        first_port_line_one_in,
  output wire logic        first_port_line_one_out,
  output wire logic        first_port_line_one_oe,
  input  wire logic        first_port_line_two_in,
  output wire logic        first_port_line_two_out,
  output wire logic        first_port_line_two_oe,
  input  wire logic        first_port_line_three_in,
  output wire logic        first_port_line_three_out,
  output wire logic        first_port_line_three_oe,
  input  wire logic        first_port_line_four_in,
  output wire logic        first_port_line_four_out,
  output wire logic        first_port_line_four_oe,
  input  wire logic        second_port_line_zero_in,
  output wire logic        second_port_line_zero_out,
  output wire logic        second_port_line_zero_oe,
  input  wire logic        second_port_line_one_in,
  output wire logic        second_port_line_one_out,
  output wire logic        second_port_line_one_oe
);

  typedef struct packed {
    gpd_pkg::gpd_bus_st_t st;
    logic                 pready;
    logic                 pslverr;
    logic [31:0]          prdata;
  } gpd_top_st_t;

  gpd_top_st_t st_r;
  gpd_top_st_t st_nxt;

  gpd_port_if #(.W(P0_W)) p0_if ();
  gpd_port_if #(.W(P1_W)) p1_if ();

  localparam int NPIN = P0_W + P1_W;

  logic [P0_W-1:0] p0_pin_in;
  logic [P1_W-1:0] p1_pin_in;
  logic            hit_p0;
  logic            hit_p1;
  logic            hit_any;
  logic            lane_dir;
  logic            lane_out;
  logic            done_wr;
  logic [31:0]     p0_word;
  logic [31:0]     p1_word;
  logic [31:0]     rd_word;
  logic [NPIN-1:0] pad_out;
  logic [NPIN-1:0] pad_oe;

  assign p0_pin_in = {first_port_line_four_in,
                      first_port_line_three_in,
                      first_port_line_two_in,
                      first_port_line_one_in,
                      first_port_line_zero_in};
  assign p1_pin_in = {second_port_line_one_in,
                      second_port_line_zero_in};

  // exact word match; every other address answers with an error
  assign hit_p0 = (paddr == gpd_pkg::P0_ADDR); // see RQ10
  assign hit_p1 = (paddr == gpd_pkg::P1_ADDR); // see RQ9
  assign hit_any = hit_p0 || hit_p1;

  // a write lands only on the edge that completes the access phase
  assign done_wr = psel && penable && st_r.pready && pwrite;

  // a cleared byte lane leaves its field as it was;
  // lanes 1 and 0 carry only pin levels and reserved bits
  assign lane_dir = pstrb[gpd_pkg::DIR_LANE];
  assign lane_out = pstrb[gpd_pkg::OUT_LANE];

  // pin-level bits are never fed to storage, so writes to them vanish;
  // reserved bits in the write data are likewise dropped
  assign p0_if.wr_dir = done_wr && hit_p0 && lane_dir;
  assign p0_if.wr_out = done_wr && hit_p0 && lane_out;
  assign p0_if.dir_wd = pwdata[gpd_pkg::DIR_LSB +: P0_W]; // see RQ1
  assign p0_if.out_wd = pwdata[gpd_pkg::OUT_LSB +: P0_W]; // see RQ2
  assign p1_if.wr_dir = done_wr && hit_p1 && lane_dir;
  assign p1_if.wr_out = done_wr && hit_p1 && lane_out;
  assign p1_if.dir_wd = pwdata[gpd_pkg::DIR_LSB +: P1_W]; // see RQ6
  assign p1_if.out_wd = pwdata[gpd_pkg::OUT_LSB +: P1_W]; // see RQ7

  gpd_port #(
    .W       (P0_W)
  ) u_port0 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (p0_pin_in),
    .bus     (p0_if)
  );

  gpd_port #(
    .W       (P1_W)
  ) u_port1 (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (p1_pin_in),
    .bus     (p1_if)
  );

  // read words: reserved bits read as zero
  always_comb begin
    p0_word = '0;
    p0_word[gpd_pkg::DIR_LSB +: P0_W] = p0_if.dir;
    p0_word[gpd_pkg::OUT_LSB +: P0_W] = p0_if.out;
    p0_word[gpd_pkg::IN_LSB +: P0_W]  = p0_if.pin_lvl; // see RQ3
  end

  always_comb begin
    p1_word = '0;
    p1_word[gpd_pkg::DIR_LSB +: P1_W] = p1_if.dir;
    p1_word[gpd_pkg::OUT_LSB +: P1_W] = p1_if.out;
    p1_word[gpd_pkg::IN_LSB +: P1_W]  = p1_if.pin_lvl; // see RQ8
  end

  // writes and unmapped addresses answer with a zero word;
  // the answer flop below keeps prdata straight from a register
  always_comb begin
    rd_word = gpd_pkg::RDATA_RST;
    if (!pwrite && hit_p0) begin
      rd_word = p0_word;
    end else if (!pwrite && hit_p1) begin
      rd_word = p1_word;
    end
  end

  // one wait state keeps pready and prdata straight from flops
  always_comb begin
    st_nxt         = st_r;
    st_nxt.pready  = 1'b0;
    st_nxt.pslverr = 1'b0;
    unique case (st_r.st)
      gpd_pkg::GPD_IDLE: begin
        if (psel && penable) begin
          st_nxt.st      = gpd_pkg::GPD_ACK;
          st_nxt.pready  = 1'b1;
          st_nxt.pslverr = !hit_any;
          st_nxt.prdata  = rd_word;
        end
      end
      gpd_pkg::GPD_ACK: begin
        // transfer completes this edge; back to idle for the next setup
        st_nxt.st = gpd_pkg::GPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.st      <= gpd_pkg::GPD_IDLE;
      st_r.pready  <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.prdata  <= gpd_pkg::RDATA_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign prdata  = st_r.prdata;
  assign pready  = st_r.pready;
  assign pslverr = st_r.pslverr;

  // one flat view of every pad, port 0 in the low bits;
  // _out follows the output bit even while the pin is an input,
  // the pad itself gates it with _oe
  for (genvar i = 0; i < NPIN; i++) begin : g_pad
    if (i < P0_W) begin : g_p0
      assign pad_out[i] = p0_if.out[i]; // see RQ2
      assign pad_oe[i]  = p0_if.dir[i]; // see RQ1 see RQ11
    end else begin : g_p1
      assign pad_out[i] = p1_if.out[i-P0_W]; // see RQ7
      assign pad_oe[i]  = p1_if.dir[i-P0_W]; // see RQ6 see RQ11
    end
  end

  // pin drivers come straight from the port flops
  assign first_port_line_zero_out  = pad_out[0];
  assign first_port_line_one_out   = pad_out[1];
  assign first_port_line_two_out   = pad_out[2];
  assign first_port_line_three_out = pad_out[3];
  assign first_port_line_four_out  = pad_out[4];
  assign first_port_line_zero_oe   = pad_oe[0];
  assign first_port_line_one_oe    = pad_oe[1];
  assign first_port_line_two_oe    = pad_oe[2];
  assign first_port_line_three_oe  = pad_oe[3];
  assign first_port_line_four_oe   = pad_oe[4];
  assign second_port_line_zero_out = pad_out[P0_W];
  assign second_port_line_one_out  = pad_out[P0_W+1];
  assign second_port_line_zero_oe  = pad_oe[P0_W];
  assign second_port_line_one_oe   = pad_oe[P0_W+1];
endmodule

// [include/gpd_pkg.sv]
// shared constants for the two-port gpio data block
package gpd_pkg;

  localparam int          P0_W        = 5;
  localparam int          P1_W        = 2;
  localparam int          DIR_LSB     = 24;
  localparam int          OUT_LSB     = 16;
  localparam int          IN_LSB      = 0;
  localparam int          DIR_LANE    = 3;
  localparam int          OUT_LANE    = 2;
  localparam logic [31:0] P0_ADDR     = 32'hffff_0d20;
  localparam logic [31:0] P1_ADDR     = 32'hffff_0d30;
  localparam logic        DIR_RST     = 1'h0;
  localparam logic        OUT_RST     = 1'h0;
  localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

  typedef enum logic [0:0] {
    GPD_IDLE = 1'b0,
    GPD_ACK  = 1'b1
  } gpd_bus_st_t;

endpackage

// [include/gpd_port_if.sv]
// link between the register decoder and one port's storage
`timescale 1ns/1ps
interface gpd_port_if #(
  parameter int W = 5
);
  logic         wr_dir;
  logic         wr_out;
  logic [W-1:0] dir_wd;
  logic [W-1:0] out_wd;
  logic [W-1:0] dir;
  logic [W-1:0] out;
  logic [W-1:0] pin_lvl;

  modport ctl (
    output wr_dir,
    output wr_out,
    output dir_wd,
    output out_wd,
    input  dir,
    input  out,
    input  pin_lvl
  );

  modport port (
    input  wr_dir,
    input  wr_out,
    input  dir_wd,
    input  out_wd,
    output dir,
    output out,
    output pin_lvl
  );
endinterface

// [tb/gpd_pin_model.sv]
// external pins: pads follow the port when it drives, else the far side
`timescale 1ns/1ps
module gpd_pin_model (
  input  wire logic [6:0] oe,
  input  wire logic [6:0] ot,
  input  wire logic [6:0] drv,
  output wire logic [6:0] pin
);
  assign pin = (oe & ot) | (~oe & drv);
endmodule

// [tb/gpd_top_asserts.sv]
// protocol and register checks on the gpio data block ports
`timescale 1ns/1ps
module gpd_top_asserts (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        first_port_line_zero_oe,
  input wire logic        first_port_line_zero_out,
  input wire logic        second_port_line_one_oe
);
  logic h0, h1, wr;
  assign h0 = paddr == gpd_pkg::P0_ADDR;
  assign h1 = paddr == gpd_pkg::P1_ADDR;
  assign wr = pready && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ack_one_wait: assert property
    (psel && penable && !pready |=> pready)
    else $error("no ack one cycle after access");
  a_ack_pulse: assert property
    (pready |=> !pready)
    else $error("ack held too long");
  a_unmapped_err: assert property
    (pready |-> pslverr == !(h0 || h1))
    else $error("error flag wrong for address");
  a_err_zero_data: assert property
    (pslverr |-> prdata == 32'h0000_0000)
    else $error("read data not zero on error");
  a_p0_dir_write: assert property
    (wr && h0 && pstrb[3] |=> first_port_line_zero_oe == $past(pwdata[24]))
    else $error("port0 pin0 direction not taken");
  a_p0_out_write: assert property
    (wr && h0 && pstrb[2] |=> first_port_line_zero_out == $past(pwdata[16]))
    else $error("port0 pin0 output not taken");
  a_p1_dir_write: assert property
    (wr && h1 && pstrb[3] |=> second_port_line_one_oe == $past(pwdata[25]))
    else $error("port1 pin1 direction not taken");
  a_p0_read_dir: assert property
    (pready && !pwrite && h0 |-> prdata[24] == first_port_line_zero_oe)
    else $error("port0 direction readback wrong");
  a_oe_hold: assert property
    (!(wr && h0 && pstrb[3]) |=> $stable(first_port_line_zero_oe))
    else $error("direction changed without write");
  cover property (pready && pslverr);
  cover property (wr && h1);
  cover property (pready && !pwrite && h0);
endmodule
bind gpd_top gpd_top_asserts chk_u (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .first_port_line_zero_oe, .first_port_line_zero_out,
  .second_port_line_one_oe);

// [tb/gpio_port0_port1_data_bench.sv]
// self-checking bench for the two-port gpio data registers
`timescale 1ns/1ps
module gpio_port0_port1_data_bench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd, sd, a, wd, ev;
  logic [3:0]  pstrb = '0;
  logic        pready, pslverr, er, bad;
  logic [6:0]  oe, ot, pin, drv = '0;
  logic [4:0]  d0 = '0, o0 = '0;
  logic [1:0]  d1 = '0, o1 = '0;
  int          error_cnt = 0, total_checks = 0;
  always #2.5 pclk = ~pclk;
  gpd_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr,
    .first_port_line_zero_in(pin[0]), .first_port_line_zero_out(ot[0]),
    .first_port_line_zero_oe(oe[0]), .first_port_line_one_in(pin[1]),
    .first_port_line_one_out(ot[1]), .first_port_line_one_oe(oe[1]),
    .first_port_line_two_in(pin[2]), .first_port_line_two_out(ot[2]),
    .first_port_line_two_oe(oe[2]), .first_port_line_three_in(pin[3]),
    .first_port_line_three_out(ot[3]), .first_port_line_three_oe(oe[3]),
    .first_port_line_four_in(pin[4]), .first_port_line_four_out(ot[4]),
    .first_port_line_four_oe(oe[4]), .second_port_line_zero_in(pin[5]),
    .second_port_line_zero_out(ot[5]), .second_port_line_zero_oe(oe[5]),
    .second_port_line_one_in(pin[6]), .second_port_line_one_out(ot[6]),
    .second_port_line_one_oe(oe[6]));
  gpd_pin_model pins_u (.oe, .ot, .drv, .pin);
  function logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function logic [31:0] ex(input logic [4:0] d, o, x);
    return {3'h0, d, 3'h0, o, 11'h000, (d & o) | (~d & x)};
  endfunction
  task chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [31:0] ad, dt, input logic [3:0] s);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, ad, dt, s};
    @(posedge pclk);
    penable <= 1;
    // only the watchdog ends a wait that never completes
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task verify;
    apb(0, gpd_pkg::P0_ADDR, '0, '0);
    chk("port0 word", ex(d0, o0, drv[4:0]), rd);
    apb(0, gpd_pkg::P1_ADDR, '0, '0);
    ev = ex({3'h0, d1}, {3'h0, o1}, {3'h0, drv[6:5]});
    chk("port1 word", ev, rd);
    chk("pin enables", {25'h0, d1, d0}, {25'h0, oe});
    chk("pin outputs", {25'h0, o1, o0}, {25'h0, ot});
  endtask
  task results;
    if (error_cnt == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1;
    verify;
    sd = 32'h0001_0549;
    for (int i = 0; i < 40; i++) begin
      sd = nx(sd);
      drv <= sd[6:0];
      bad = i % 8 == 3;
      a = sd[12] ? gpd_pkg::P1_ADDR : gpd_pkg::P0_ADDR;
      if (bad) a = gpd_pkg::P1_ADDR + 32'h0000_0010;
      // pin bits sometimes set on purpose: they must be ignored
      wd = {3'h0, sd[28:24], 3'h0, sd[20:16], 11'h000, {5{i[1]}}};
      if (a == gpd_pkg::P1_ADDR) wd &= 32'h0303_0003;
      apb(1, a, wd, sd[11:8]);
      if (!bad && a == gpd_pkg::P0_ADDR) begin
        if (sd[11]) d0 = wd[28:24];
        if (sd[10]) o0 = wd[20:16];
      end else if (!bad) begin
        if (sd[11]) d1 = wd[25:24];
        if (sd[10]) o1 = wd[17:16];
      end
      chk("error flag", {31'h0, bad}, {31'h0, er});
      repeat (3) @(posedge pclk);
      verify;
    end
    presetn <= 0;
    @(posedge pclk);
    presetn <= 1;
    {d0, o0, d1, o1} = '0;
    verify;
    results;
  end
  initial begin
    #20000;
    error_cnt++;
    results;
  end
endmodule
